// file: pfc_board.sv
/*
  pfc_board: board circuitry on one port, resolves every pad wire level.
  assumes pad drive comes from the block and board drive from the bench.
*/
`timescale 1ns/10ps
module pfc_board #(
  parameter int unsigned W = 8                    // port width
) (
  input  wire logic         clk,                  // system clock
  input  wire logic [W-1:0] out,                  // block output level
  input  wire logic [W-1:0] oeN,                  // block drives when low
  input  wire logic [W-1:0] pull,                 // block pull-up on
  input  wire logic [W-1:0] extEn,                // board drives the wire
  input  wire logic [W-1:0] extVal,               // board drive level
  output logic      [W-1:0] pin                   // resolved wire level
);
  logic [W-1:0] floatQ = '0;                      // floating wire noise
  // an undriven wire without pull-up changes every cycle
  always @(posedge clk) begin
    floatQ <= ~floatQ;
  end
  // block drive wins, then board, then pull-up, else noise
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = !oeN[i] ? out[i] : extEn[i] ? extVal[i] : pull[i] ? 1'b1 : floatQ[i];
    end
  end
endmodule : pfc_board

// file: pfc_pkg.sv
/*
  pfc_pkg: constants, types and register map of the port pin function block.
  assumes a 20 MHz system clock and word-aligned Avalon-MM byte addresses.
*/
package pfc_pkg;
  // port widths
  localparam int unsigned FIRST_W  = 8;           // first port bits
  localparam int unsigned SECOND_W = 7;           // second port bits
  localparam int unsigned THIRD_W  = 8;           // third port bits
  // special pin positions
  localparam int unsigned OSC_IN_BIT  = 6;        // first port pin six
  localparam int unsigned OSC_OUT_BIT = 7;        // first port pin seven
  localparam int unsigned RST_PIN_BIT = 6;        // second port top pin
  // clock and reset filter timing
  localparam int unsigned CLK_MHZ          = 20;  // system clock rate
  localparam int unsigned RST_MIN_PULSE_NS = 2500; // minimum reset pulse, ns
  localparam int unsigned RST_MIN_CYCLES   = (RST_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_CNT_W        = 12;  // filter counter width
  // bus shape
  localparam int unsigned ADDR_W = 8;             // byte address bits
  localparam int unsigned DATA_W = 32;            // data bits
  // register byte offsets
  localparam logic [7:0] FIRST_OUT_OFS   = 8'h00; // first port output data
  localparam logic [7:0] FIRST_DIR_OFS   = 8'h04; // first port direction
  localparam logic [7:0] FIRST_PULL_OFS  = 8'h08; // first port pull-up enable
  localparam logic [7:0] FIRST_PIN_OFS   = 8'h0c; // first port pin level
  localparam logic [7:0] SECOND_OUT_OFS  = 8'h10; // second port output data
  localparam logic [7:0] SECOND_DIR_OFS  = 8'h14; // second port direction
  localparam logic [7:0] SECOND_PULL_OFS = 8'h18; // second port pull-up enable
  localparam logic [7:0] SECOND_PIN_OFS  = 8'h1c; // second port pin level
  localparam logic [7:0] THIRD_OUT_OFS   = 8'h20; // third port output data
  localparam logic [7:0] THIRD_DIR_OFS   = 8'h24; // third port direction
  localparam logic [7:0] THIRD_PULL_OFS  = 8'h28; // third port pull-up enable
  localparam logic [7:0] THIRD_PIN_OFS   = 8'h2c; // third port pin level
  localparam logic [7:0] ASYNC_CTRL_OFS  = 8'h30; // async timer clock select
  localparam logic [7:0] FUNC_STAT_OFS   = 8'h34; // pin function status
  // status bit positions
  localparam int unsigned STAT_RSTFN_BIT = 0;     // reset pin function active
  localparam int unsigned STAT_XTAL_BIT  = 1;     // crystal owns osc pins
  localparam int unsigned STAT_TOSC_BIT  = 2;     // timer osc owns osc pins
  localparam int unsigned STAT_PINRST_BIT = 3;    // reset seen, high in the cycle after any reset
  // reset values
  localparam logic [7:0] PORT_RST = 8'h00;        // all registers clear
  localparam logic [31:0] DATA_RST = 32'h0000_0000; // read data at reset

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    PFC_IDLE = 2'b01,                             // waiting for a request
    PFC_ACK  = 2'b10                              // answering, waitrequest low
  } pfc_bus_t;

  // avalon request from master
  typedef struct packed {
    logic [ADDR_W-1:0] address;                   // byte address
    logic              read;                      // read strobe
    logic              write;                     // write strobe
    logic [DATA_W-1:0] writedata;                 // write data
  } pfc_avs_req_t;

  // avalon answer to master
  typedef struct packed {
    logic [DATA_W-1:0] readdata;                  // read data
    logic              waitrequest;               // stall, high until answer
  } pfc_avs_rsp_t;

  // pad drive of an eight-bit port
  typedef struct packed {
    logic [7:0] out;                              // pad output level
    logic [7:0] oeN;                              // low drives the pad
    logic [7:0] pull;                             // pull-up on
  } pfc_pad8_t;

  // pad drive of the seven-bit port
  typedef struct packed {
    logic [6:0] out;                              // pad output level
    logic [6:0] oeN;                              // low drives the pad
    logic [6:0] pull;                             // pull-up on
  } pfc_pad7_t;

  // configuration of one port as software sets it
  typedef struct packed {
    logic [7:0] out;                              // output data
    logic [7:0] dir;                              // one drives
    logic [7:0] pull;                             // pull-up request
  } pfc_cfg_t;
endpackage : pfc_pkg

// file: pfc_port_ctrl.sv
/*
  pfc_port_ctrl: three general-purpose ports with pull-ups, reset pin and
  oscillator pin functions, registers over Avalon-MM with waitrequest.
  assumes pins are synchronous to clk; pad wire levels are resolved outside.
  // Contract
  // - first port: eight pins, per-bit pull-ups
  // - second port: seven pins, per-bit pull-ups
  // - third port: eight pins, per-bit pull-ups
  // - any reset releases every pin asynchronously
  // - reset-disable fuse makes top pin ordinary
  // - long low on reset pin resets
  // - clock fuses give pins six, seven oscillator
  // - RC clock plus select: timer oscillator
*/
`timescale 1ns/10ps
module pfc_port_ctrl #(
  parameter int unsigned RST_CYCLES = pfc_pkg::RST_MIN_CYCLES // reset pin filter length
) (
  input  wire logic                clk,           // system clock
  input  wire logic                nrst,          // power-on reset, active low
  input  pfc_pkg::pfc_avs_req_t    avsReq,        // avalon request
  output pfc_pkg::pfc_avs_rsp_t    avsRsp,        // avalon answer
  input  wire logic                resetPinDisableFuse, // one: top pin is i/o
  input  wire logic                crystalClockFuse,    // one: crystal clocks chip
  input  wire logic                internalRcFuse,      // one: RC clocks chip
  input  wire logic [7:0]          firstPin,      // first port pad levels
  input  wire logic [6:0]          secondPin,     // second port pad levels
  input  wire logic [7:0]          thirdPin,      // third port pad levels
  output pfc_pkg::pfc_pad8_t       firstPad,      // first port pad drive
  output pfc_pkg::pfc_pad7_t       secondPad,     // second port pad drive
  output pfc_pkg::pfc_pad8_t       thirdPad,      // third port pad drive
  output logic                     oscAmpIn,      // pin six to oscillator amp
  output logic                     timerOscIn,    // pin six to timer oscillator
  output logic                     resetOut       // chip reset, active high
);
  import pfc_pkg::*;

  // whole state of the block
  typedef struct packed {
    pfc_bus_t      bus;                           // handshake state
    pfc_avs_rsp_t  rsp;                           // bus answer
    pfc_cfg_t      first;                         // first port settings
    pfc_cfg_t      second;                        // second port settings
    pfc_cfg_t      third;                         // third port settings
    logic          asyncSel;                      // async timer clock select
    pfc_pad8_t     firstPad;                      // first pad drive
    pfc_pad7_t     secondPad;                     // second pad drive
    pfc_pad8_t     thirdPad;                      // third pad drive
    logic          oscAmpIn;                      // oscillator feed
    logic          timerOscIn;                    // timer oscillator feed
    logic          resetOut;                      // reset seen
  } pfc_state_t;

  pfc_state_t st_q;                               // registered state
  pfc_state_t st_d;                               // next state

  logic        pinRst;                            // filtered reset pin request
  logic        rstN;                              // combined reset, active low
  logic        rstFn;                             // top pin is reset input
  logic        xtalOwn;                           // crystal owns osc pins
  logic        toscOwn;                           // timer osc owns osc pins
  logic [7:0]  oscMask;                           // first port bits taken away
  logic [6:0]  rstMask;                           // second port bit taken away
  logic [31:0] rdMux;                             // read data select
  logic [31:0] statWord;                          // pin function status

  // pin function selection from fuses and select bit
  assign rstFn   = !resetPinDisableFuse;
  assign xtalOwn = crystalClockFuse;
  assign toscOwn = internalRcFuse && st_q.asyncSel;
  assign oscMask = (xtalOwn || toscOwn) ? 8'hc0 : 8'h00;
  assign rstMask = rstFn ? 7'h40 : 7'h00;

  // long low on the reset pin becomes a reset request
  pfc_rst_filter #(
    .MIN_CYCLES (RST_CYCLES)
  ) u_rst_filter (
    .clk      (clk),
    .nrst     (nrst),
    .enable   (rstFn),
    .pinLevel (secondPin[RST_PIN_BIT]),
    .rstReq   (pinRst)
  );

  // either source of reset clears the block and releases the pins
  assign rstN = nrst && !pinRst;

  // status word of pin functions
  always_comb begin
    statWord = DATA_RST;
    statWord[STAT_RSTFN_BIT]  = rstFn;
    statWord[STAT_XTAL_BIT]   = xtalOwn;
    statWord[STAT_TOSC_BIT]   = toscOwn;
    statWord[STAT_PINRST_BIT] = st_q.resetOut;
  end

  // read data decode, unmapped reads zero
  always_comb begin
    case (avsReq.address)
      FIRST_OUT_OFS:   rdMux = {24'h000000, st_q.first.out};
      FIRST_DIR_OFS:   rdMux = {24'h000000, st_q.first.dir};
      FIRST_PULL_OFS:  rdMux = {24'h000000, st_q.first.pull};
      FIRST_PIN_OFS:   rdMux = {24'h000000, firstPin};
      SECOND_OUT_OFS:  rdMux = {25'h0000000, st_q.second.out[6:0]};
      SECOND_DIR_OFS:  rdMux = {25'h0000000, st_q.second.dir[6:0]};
      SECOND_PULL_OFS: rdMux = {25'h0000000, st_q.second.pull[6:0]};
      SECOND_PIN_OFS:  rdMux = {25'h0000000, secondPin};
      THIRD_OUT_OFS:   rdMux = {24'h000000, st_q.third.out};
      THIRD_DIR_OFS:   rdMux = {24'h000000, st_q.third.dir};
      THIRD_PULL_OFS:  rdMux = {24'h000000, st_q.third.pull};
      THIRD_PIN_OFS:   rdMux = {24'h000000, thirdPin};
      ASYNC_CTRL_OFS:  rdMux = {31'h00000000, st_q.asyncSel};
      FUNC_STAT_OFS:   rdMux = statWord;
      default:         rdMux = DATA_RST;          // unmapped address
    endcase
  end

  // next state: bus handshake, register writes, pad drive
  always_comb begin
    st_d = st_q;
    case (st_q.bus)
      PFC_IDLE: begin                             // take a request
        if (avsReq.read || avsReq.write) begin
          st_d.bus             = PFC_ACK;
          st_d.rsp.waitrequest = 1'b0;
          st_d.rsp.readdata    = avsReq.read ? rdMux : DATA_RST;
        end
      end
      PFC_ACK: begin                              // master samples answer here
        st_d.bus             = PFC_IDLE;
        st_d.rsp.waitrequest = 1'b1;
        if (avsReq.write) begin
          case (avsReq.address)
            FIRST_OUT_OFS:   st_d.first.out   = avsReq.writedata[7:0];
            FIRST_DIR_OFS:   st_d.first.dir   = avsReq.writedata[7:0];
            FIRST_PULL_OFS:  st_d.first.pull  = avsReq.writedata[7:0];
            SECOND_OUT_OFS:  st_d.second.out  = {1'b0, avsReq.writedata[6:0]};
            SECOND_DIR_OFS:  st_d.second.dir  = {1'b0, avsReq.writedata[6:0]};
            SECOND_PULL_OFS: st_d.second.pull = {1'b0, avsReq.writedata[6:0]};
            THIRD_OUT_OFS:   st_d.third.out   = avsReq.writedata[7:0];
            THIRD_DIR_OFS:   st_d.third.dir   = avsReq.writedata[7:0];
            THIRD_PULL_OFS:  st_d.third.pull  = avsReq.writedata[7:0];
            ASYNC_CTRL_OFS:  st_d.asyncSel    = avsReq.writedata[0];
            default:         st_d.asyncSel    = st_q.asyncSel; // read-only or unmapped
          endcase
        end
      end
      default: begin                              // illegal code, recover
        st_d.bus             = PFC_IDLE;
        st_d.rsp.waitrequest = 1'b1;
      end
    endcase
    // first port: drive when output, pull-up only as input; osc pins released
    st_d.firstPad.oeN  = ~st_q.first.dir | oscMask;
    st_d.firstPad.out  = st_q.first.out & st_q.first.dir & ~oscMask;
    st_d.firstPad.pull = st_q.first.pull & ~st_q.first.dir & ~oscMask;
    // second port: top pin is an input with pull-up while it serves reset
    st_d.secondPad.oeN  = ~st_q.second.dir[6:0] | rstMask;
    st_d.secondPad.out  = st_q.second.out[6:0] & st_q.second.dir[6:0] & ~rstMask;
    st_d.secondPad.pull = (st_q.second.pull[6:0] & ~st_q.second.dir[6:0]) | rstMask;
    // third port: plain i/o
    st_d.thirdPad.oeN  = ~st_q.third.dir;
    st_d.thirdPad.out  = st_q.third.out & st_q.third.dir;
    st_d.thirdPad.pull = st_q.third.pull & ~st_q.third.dir;
    // oscillator feeds from pin six
    st_d.oscAmpIn   = xtalOwn && firstPin[OSC_IN_BIT];
    st_d.timerOscIn = toscOwn && !xtalOwn && firstPin[OSC_IN_BIT];
    st_d.resetOut   = 1'b0;
  end

  // state register; reset releases pins without waiting for clk
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_q                     <= '0;
      st_q.bus                 <= PFC_IDLE;
      st_q.rsp.waitrequest     <= 1'b1;
      st_q.firstPad.oeN        <= 8'hff;
      st_q.secondPad.oeN       <= 7'h7f;
      st_q.thirdPad.oeN        <= 8'hff;
      st_q.resetOut            <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avsRsp     = st_q.rsp;
  assign firstPad   = st_q.firstPad;
  assign secondPad  = st_q.secondPad;
  assign thirdPad   = st_q.thirdPad;
  assign oscAmpIn   = st_q.oscAmpIn;
  assign timerOscIn = st_q.timerOscIn;
  assign resetOut   = st_q.resetOut;

  // pins released in the first cycle after any reset
  pins_released_a: assert property (@(posedge clk) disable iff (!rstN)
    $past(st_q.resetOut) |-> (&firstPad.oeN && &secondPad.oeN && &thirdPad.oeN))
    else $error("pins driven after reset");
  // pull-up follows the pull bit on an input of the first port
  first_pull_a: assert property (@(posedge clk) disable iff (!rstN)
    firstPad.pull[0] == $past(st_q.first.pull[0] && !st_q.first.dir[0]))
    else $error("first port pull wrong");
  // second port low pin drives exactly when set as output
  second_drive_a: assert property (@(posedge clk) disable iff (!rstN)
    secondPad.oeN[0] == $past(!st_q.second.dir[0])) else $error("second drive wrong");
  // third port output level follows data when driving
  third_out_a: assert property (@(posedge clk) disable iff (!rstN)
    (!thirdPad.oeN[3]) |-> thirdPad.out[3] == $past(st_q.third.out[3]))
    else $error("third out wrong");
  // reset pin never driven while serving reset, once pads left reset values
  reset_pin_a: assert property (@(posedge clk) disable iff (!rstN)
    ($past(rstFn) && !st_q.resetOut) |-> (secondPad.oeN[6] && secondPad.pull[6]))
    else $error("reset pin driven");
  // crystal takes both oscillator pins
  xtal_pins_a: assert property (@(posedge clk) disable iff (!rstN)
    $past(xtalOwn) |-> (firstPad.oeN[7:6] == 2'b11 && firstPad.pull[7:6] == 2'b00))
    else $error("osc pins used as i/o");
  // timer oscillator feed needs RC clock and select
  tosc_feed_a: assert property (@(posedge clk) disable iff (!rstN)
    timerOscIn |-> $past(internalRcFuse && st_q.asyncSel)) else $error("timer osc feed");
  // one cycle of waitrequest low after each taken request
  bus_answer_a: assert property (@(posedge clk) disable iff (!rstN)
    (st_q.bus == PFC_IDLE && (avsReq.read || avsReq.write))
      |=> !avsRsp.waitrequest ##1 avsRsp.waitrequest) else $error("bus answer timing");
  // write lands on the answer edge
  bus_write_a: assert property (@(posedge clk) disable iff (!rstN)
    (!avsRsp.waitrequest && avsReq.write && avsReq.address == ASYNC_CTRL_OFS)
      |=> st_q.asyncSel == $past(avsReq.writedata[0])) else $error("write lost");

  bus_read_c:  cover property (@(posedge clk) disable iff (!rstN)
    !avsRsp.waitrequest && avsReq.read);
  tosc_on_c:   cover property (@(posedge clk) disable iff (!rstN) timerOscIn);
  drive_out_c: cover property (@(posedge clk) disable iff (!rstN) !firstPad.oeN[0]);
endmodule : pfc_port_ctrl

// file: pfc_port_ctrl_tb.sv
/*
  pfc_port_ctrl_tb: register, pin function and reset checks of the port block.
  assumes a 20 MHz clock and a board model on each of the three ports.
*/
`timescale 1ns/10ps
module pfc_port_ctrl_tb;
  import pfc_pkg::*;
  localparam int RSTC = 3;                        // short reset pin filter
  logic clk = 1'b0, nrst = 1'b0, rpd = 1'b1, xtal = 1'b0, rc = 1'b0;
  pfc_avs_req_t req = '0;                         // bus request
  pfc_avs_rsp_t rsp;                              // bus answer
  pfc_pad8_t    pad1, pad3;                       // eight-bit pad drive
  pfc_pad7_t    pad2;                             // seven-bit pad drive
  logic [7:0]   pin1, pin3, e1En = 8'h30, e1Val = 8'h00, e3En = 8'h30;
  logic [6:0]   pin2, e2En = 7'h30, e2Val = 7'h00;
  logic         oscAmp, timerOsc, rstOut;         // pin function outputs
  int           numErrors = 0, checkCount = 0;
  logic [31:0]  r, m, pv;                         // scratch
  logic [7:0]   b;                                // port base offset

  pfc_port_ctrl #(.RST_CYCLES(RSTC)) dut (.clk(clk), .nrst(nrst), .avsReq(req), .avsRsp(rsp),
    .resetPinDisableFuse(rpd), .crystalClockFuse(xtal), .internalRcFuse(rc),
    .firstPin(pin1), .secondPin(pin2), .thirdPin(pin3), .firstPad(pad1), .secondPad(pad2),
    .thirdPad(pad3), .oscAmpIn(oscAmp), .timerOscIn(timerOsc), .resetOut(rstOut));
  pfc_board #(.W(8)) brd1 (.clk(clk), .out(pad1.out), .oeN(pad1.oeN), .pull(pad1.pull),
    .extEn(e1En), .extVal(e1Val), .pin(pin1));
  pfc_board #(.W(7)) brd2 (.clk(clk), .out(pad2.out), .oeN(pad2.oeN), .pull(pad2.pull),
    .extEn(e2En), .extVal(e2Val), .pin(pin2));
  pfc_board #(.W(8)) brd3 (.clk(clk), .out(pad3.out), .oeN(pad3.oeN), .pull(pad3.pull),
    .extEn(e3En), .extVal(8'h00), .pin(pin3));

  // clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.address <= a;
    req.read <= !w;
    req.write <= w;
    req.writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      numErrors++;
      $display("ERROR %0t: bus hang", $time);
    end
    r = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask : rdc
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  // verdict and end of run
  task automatic completeRun();
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : completeRun
  // watchdog against a hang
  initial begin
    #(50 * 20000);
    numErrors++;
    $display("ERROR %0t: watchdog expired", $time);
    completeRun();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc(FIRST_OUT_OFS, 32'h0);
    // each port: data, direction, pull-up, pin level, read-only pin register
    for (int p = 0; p < 3; p++) begin
      m = (p == 1) ? 32'h7f : 32'hff;
      b = 8'(p * 16);
      wr(b, 32'h3c);
      wr(b + 8'h04, 32'h0f);
      wr(b + 8'h08, 32'hf0);
      settle();
      pv = (p == 0) ? {8'h0, pad1} : (p == 1) ?
           {9'h0, pad2.out, 1'b0, pad2.oeN, 1'b0, pad2.pull} : {8'h0, pad3};
      chk(pv, {8'h0, 8'h0c, 8'hf0 & m[7:0], 8'hf0 & m[7:0]});
      rdc(b + 8'h08, 32'hf0 & m);
      wr(b + 8'h0c, 32'hff);
      rdc(b + 8'h0c, 32'hcc & m);
    end
    wr(8'h40, 32'hff);
    rdc(8'h40, 32'h0);
    // crystal owns pins six and seven
    @(posedge clk) begin xtal <= 1'b1; e1En <= 8'h70; e1Val <= 8'h40; end
    wr(FIRST_DIR_OFS, 32'hcf);
    settle();
    chk(pad1.oeN[7:6], 2'b11);
    chk(oscAmp, 1'b1);
    rdc(FUNC_STAT_OFS, 32'h2);
    @(posedge clk) e1Val <= 8'h00;
    settle();
    chk(oscAmp, 1'b0);
    // RC clock: timer oscillator only once selected
    @(posedge clk) begin xtal <= 1'b0; rc <= 1'b1; e1Val <= 8'h40; end
    settle();
    chk({pad1.oeN[7:6], timerOsc}, 3'b000);
    wr(ASYNC_CTRL_OFS, 32'h1);
    settle();
    chk({pad1.oeN[7:6], timerOsc, oscAmp}, 4'b1110);
    rdc(FUNC_STAT_OFS, 32'h4);
    // crystal fuse wins over the timer oscillator
    @(posedge clk) xtal <= 1'b1;
    settle();
    chk({timerOsc, oscAmp}, 2'b01);
    @(posedge clk) xtal <= 1'b0;
    // reset pin disabled: a long low is ordinary input
    @(posedge clk) e2En <= 7'h70;
    repeat (RSTC + 6) @(posedge clk);
    @(negedge clk);
    chk(rstOut, 1'b0);
    rdc(SECOND_PIN_OFS, 32'h0c);
    @(posedge clk) e2En <= 7'h30;
    settle();
    rdc(THIRD_DIR_OFS, 32'h0f);
    @(posedge clk) rpd <= 1'b0;
    settle();
    chk({pad2.oeN[6], pad2.pull[6]}, 2'b11);
    rdc(FUNC_STAT_OFS, 32'h5);
    // a low of the filter length is too short
    @(posedge clk) e2En <= 7'h70;
    repeat (RSTC) @(posedge clk);
    e2En <= 7'h30;
    settle();
    chk(rstOut, 1'b0);
    rdc(THIRD_DIR_OFS, 32'h0f);
    // a long low resets the block, pins released
    @(posedge clk) e2En <= 7'h70;
    repeat (RSTC + 3) @(posedge clk);
    @(negedge clk);
    chk({rstOut, pad3.oeN, pad3.pull}, {1'b1, 8'hff, 8'h00});
    @(posedge clk) e2Val <= 7'h40;
    settle();
    chk(rstOut, 1'b0);
    rdc(THIRD_DIR_OFS, 32'h0);
    // power-on reset mid-run acts before any clock edge
    wr(THIRD_DIR_OFS, 32'hff);
    settle();
    @(posedge clk) nrst <= 1'b0;
    #2;
    chk({pad1.oeN, pad2.oeN, pad3.oeN, pad3.pull}, 32'h7fffff00);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(THIRD_DIR_OFS, 32'h0);
    completeRun();
  end
endmodule : pfc_port_ctrl_tb

// file: pfc_rst_filter.sv
/*
  pfc_rst_filter: qualifies a low level on the reset pin by a minimum length.
  assumes the pin level is synchronous to clk and nrst is the power-on reset.
*/
`timescale 1ns/10ps
module pfc_rst_filter #(
  parameter int unsigned MIN_CYCLES = pfc_pkg::RST_MIN_CYCLES // qualifying low length
) (
  input  wire logic clk,                          // system clock
  input  wire logic nrst,                         // power-on reset, active low
  input  wire logic enable,                       // reset pin function active
  input  wire logic pinLevel,                     // reset pin level
  output logic      rstReq                        // reset request, level
);
  import pfc_pkg::*;

  // filter state
  typedef struct packed {
    logic [RST_CNT_W-1:0] cnt;                    // low cycles seen
    logic                 req;                    // request output
  } pfc_flt_t;

  pfc_flt_t st_q;                                 // registered state
  pfc_flt_t st_d;                                 // next state

  localparam logic [RST_CNT_W-1:0] LIMIT = RST_CNT_W'(MIN_CYCLES); // count target

  // count low cycles, fire once the limit is reached
  always_comb begin
    st_d = st_q;
    if (!enable || pinLevel) begin                // pin high or function off
      st_d.cnt = '0;
      st_d.req = 1'b0;
    end else if (st_q.cnt < LIMIT) begin          // still qualifying
      st_d.cnt = st_q.cnt + 1'b1;
    end else begin                                // held long enough
      st_d.req = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rstReq = st_q.req;

  // request only after the full low length
  filter_length_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st_q.req) |-> st_q.cnt == LIMIT) else $error("reset request too early");
  // request drops when the pin returns high
  filter_release_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.req && enable && pinLevel) |=> !st_q.req) else $error("request stuck");
  filter_fire_c: cover property (@(posedge clk) disable iff (!nrst) $rose(st_q.req));
endmodule : pfc_rst_filter
